// File: include/osd_pkg.sv
// shared constants and carrier types for the octal serial output driver control
//
// Behaviour
// - Each of eight channels has its own latch bit, switched independently.
// - Each transfer moves eight control bits from master into the shift register.
// - Each transfer returns eight diagnostic bits, one per channel voltage.
// - Device is selected only while chip select is low.
// - Serial output floats while deselected, driven only while selected.
// - Chip select falling loads all eight sensed levels into the shift register.
// - Chip select rising copies the inverted shift register into the output latch.
// - Each shift clock rise presents the next shift register bit on serial out.
// - Each shift clock fall samples serial input into the shift register.
// - Shifting in and shifting out happen together in one transfer.
// - Serial output passes shifted data on so devices can be chained.
// - An on output whose pin reads high is a fault; its latch bit clears.
// - Fault clearing touches only the faulted channel's latch bit.
// - Reset clears the whole output latch, turning every output off.
// - An off output with open pin reports low in its diagnostic bit.
// - Serial input one programs the output off, zero programs it on.
// - Channel 7 travels first and channel 0 last, both directions.
// - Fault clearing is suppressed for a hold time after chip select rises.
package osd_pkg;

	// channel count and shift register width
	localparam int CH_W = 8;

	// fault hold-off after chip select rises, and the system clock period
	localparam int HOLD_TIME_NS = 160000;
	localparam int CLK_PERIOD_NS = 10;
	// a least time, so it rounds up to whole cycles
	localparam int HOLD_CYCLES_DEF = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CNT_W = 15;

	// reset values
	localparam logic [CH_W-1:0] LATCH_RST = 8'h00;
	localparam logic [CH_W-1:0] SHREG_RST = 8'h00;

	// command log buffer shape
	localparam int LOG_DEPTH = 16;
	localparam int LOG_W = 8;

	// the three link pins from the master
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic si;
	} link_in_t;

endpackage

// File: logic/cmd_fifo.sv
// small synchronous fifo with registered outputs on both sides
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	// depth must be a power of two so the pointers wrap on their own
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] count;
		logic in_rdy;
		logic out_vld;
		logic [WIDTH-1:0] out_data;
	} fifo_state_t;

	fifo_state_t q, d;
	logic push, pop;

	// next state: storage plus one output register stage
	always_comb begin
		d = q;
		push = in_valid_i && q.in_rdy;
		pop = (q.count != '0) && (!q.out_vld || out_ready_i);
		if (q.out_vld && out_ready_i) begin
			d.out_vld = 1'b0;
		end
		if (pop) begin
			d.out_data = q.mem[q.rd];
			d.out_vld = 1'b1;
			d.rd = q.rd + 1'b1;
		end
		if (push) begin
			d.mem[q.wr] = in_data_i;
			d.wr = q.wr + 1'b1;
		end
		d.count = q.count + CW'(push) - CW'(pop);
		// ready is registered so the producer sees a flop, never a loop
		d.in_rdy = (d.count < CW'(DEPTH));
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.in_rdy <= 1'b1;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign in_ready_o = q.in_rdy;
	assign out_valid_o = q.out_vld;
	assign out_data_o = q.out_data;

	// a full store must refuse new words
	fifo_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(q.count == CW'(DEPTH)) |-> !in_ready_o)
		else $error("fifo accepts while full");

endmodule // cmd_fifo
`default_nettype wire

// File: logic/octal_serial_output_driver_ctrl.sv
// serial link, shift register, output latch and fault clearing of the octal driver
`timescale 1ns/1ps
`default_nettype none
module octal_serial_output_driver_ctrl
	import osd_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// device reset pin, active low, asynchronous
	input wire logic clear_n_i,
	// link pins from the master
	input wire link_in_t link_i,
	output logic so_o,
	output logic so_oe_n_o,
	// output stages: sensed pin level in, channel on out
	input wire logic [CH_W-1:0] sense_i,
	output logic [CH_W-1:0] chan_on_o,
	// log of committed command bytes
	output logic cmd_valid_o,
	output logic [LOG_W-1:0] cmd_data_o,
	input wire logic cmd_ready_i,
	output logic cmd_room_o
);

	// whole state of the block
	typedef struct packed {
		logic [1:0] sclk_s;
		logic sclk_p;
		logic [1:0] cs_s;
		logic cs_p;
		logic [1:0] si_s;
		logic [CH_W-1:0] sense_s1;
		logic [CH_W-1:0] sense_s2;
		logic [CH_W-1:0] shreg;
		logic so;
		logic so_oe_n;
		logic [CH_W-1:0] latch;
		logic [HOLD_CNT_W-1:0] hold;
	} ctrl_state_t;

	ctrl_state_t q, d;

	// either reset source clears everything at once, clock or not
	logic arst;
	// edge strobes from the synchronised pins
	logic cs_fall, cs_rise;
	logic sclk_rise, sclk_fall;
	logic sel;
	// fault mask per channel
	logic [CH_W-1:0] fault;
	// command byte pushed at chip select rise
	logic log_push;
	logic log_room;

	// edge finder shared by the shift clock and chip select pins
	function automatic logic rose(input logic prev, input logic cur);
		return !prev && cur;
	endfunction

	assign arst = rst_i || !clear_n_i;

	assign sel = !q.cs_s[1];
	assign cs_fall = rose(q.cs_s[1], q.cs_p);
	assign cs_rise = rose(q.cs_p, q.cs_s[1]);

	assign sclk_rise = sel && rose(q.sclk_p, q.sclk_s[1]);
	assign sclk_fall = sel && rose(q.sclk_s[1], q.sclk_p);

	// fault when on but pin still high
	generate
		for (genvar c = 0; c < CH_W; c++) begin : g_fault
			assign fault[c] = q.latch[c] && q.sense_s2[c];
		end
	endgenerate

	assign log_push = cs_rise;

	// next state
	always_comb begin
		d = q;
		// two-flop synchronisers; only stage two is read by logic
		d.sclk_s = {q.sclk_s[0], link_i.sclk};
		d.cs_s = {q.cs_s[0], link_i.cs_n};
		d.si_s = {q.si_s[0], link_i.si};
		d.sense_s1 = sense_i;
		d.sense_s2 = q.sense_s1;
		d.sclk_p = q.sclk_s[1];
		d.cs_p = q.cs_s[1];

		d.so_oe_n = q.cs_s[1];

		// an open off pin senses low, so it loads a zero
		if (cs_fall) begin
			// a high pin loads a one
			d.shreg = q.sense_s2;
			d.so = q.sense_s2[CH_W-1];
		end else begin
			// diagnostic bits leave one per rise
			if (sclk_rise) begin
				d.so = q.shreg[CH_W-1];
			end
			if (sclk_fall) begin
				// control bits collect in the shift register
				// in and out share one register
				d.shreg = {q.shreg[CH_W-2:0], q.si_s[1]};
			end
		end

		if (cs_rise) begin
			// a one means off, so store the inverse
			d.latch = ~q.shreg;
			d.hold = HOLD_CNT_W'(HOLD_CYCLES);
		end else if (q.hold != '0) begin
			// inrush is left to the analog limit during this window
			d.hold = q.hold - 1'b1;
		end else begin
			d.latch = q.latch & ~fault;
		end
	end

	// latch and shift register cleared by reset
	always_ff @(posedge clk_i or posedge arst) begin
		if (arst) begin
			q <= '0;
			q.sclk_s <= 2'h0;
			q.cs_s <= 2'h3;
			q.cs_p <= 1'b1;
			q.so_oe_n <= 1'b1;
			q.latch <= LATCH_RST;
			q.shreg <= SHREG_RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// one latch bit per channel drives each stage
	assign chan_on_o = q.latch;
	// shifted bits leave on serial out for chaining
	assign so_o = q.so;
	assign so_oe_n_o = q.so_oe_n;
	assign cmd_room_o = log_room;

	// command log; a full log drops the byte and shows it on cmd_room_o
	cmd_fifo #(
		.WIDTH(LOG_W),
		.DEPTH(LOG_DEPTH)
	) u_log (
		.clk_i(clk_i),
		.rst_i(arst),
		.ce_i(ce_i),
		.in_valid_i(log_push),
		.in_data_i(q.shreg),
		.in_ready_o(log_room),
		.out_valid_o(cmd_valid_o),
		.out_data_o(cmd_data_o),
		.out_ready_i(cmd_ready_i)
	);

	// deselected output must float one cycle later
	so_float_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && q.cs_s[1]) |=> so_oe_n_o)
		else $error("serial out driven while deselected");

	// selected output drives one cycle later
	so_drive_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && !q.cs_s[1]) |=> !so_oe_n_o)
		else $error("serial out floating while selected");

	// sensed levels land in the shift register at select
	diag_load_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && cs_fall) |=> (q.shreg == $past(q.sense_s2)) && (so_o == $past(q.sense_s2[7])))
		else $error("diagnostic jam missing");

	// latch takes inverted shift register at deselect
	latch_load_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && cs_rise) |=> (chan_on_o == ~$past(q.shreg)))
		else $error("latch not loaded on deselect");

	// top bit appears on serial out after a clock rise
	so_shift_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && sclk_rise && !cs_fall) |=> (so_o == $past(q.shreg[7])))
		else $error("serial out not advanced");

	// input bit enters at the bottom on a clock fall
	si_sample_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && sclk_fall && !cs_fall)
		|=> (q.shreg == {$past(q.shreg[6:0]), $past(q.si_s[1])}))
		else $error("serial input not sampled");

	// shift register frozen while deselected
	idle_freeze_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && q.cs_s[1]) |=> $stable(q.shreg))
		else $error("shift register moved while deselected");

	// hold-off counter reloads with the full count
	hold_start_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && cs_rise) |=> (q.hold == HOLD_CNT_W'(HOLD_CYCLES)))
		else $error("hold-off not started");

	// no clearing while the hold-off runs
	hold_block_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && q.hold != '0 && !cs_rise) |=> $stable(chan_on_o))
		else $error("latch changed during hold-off");

	// faulted channels, and only those, turn off
	fault_clear_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && q.hold == '0 && !cs_rise && fault != '0)
		|=> (chan_on_o == ($past(chan_on_o) & ~$past(fault))))
		else $error("fault clearing wrong");

	// faulted channel 0 is off within two cycles of its fault being seen with the hold-off over
	fault_off_a: assert property (
		@(posedge clk_i) disable iff (arst)
		(ce_i && q.hold == '0 && !cs_rise && fault[0]) ##1 ce_i |-> ##[0:1] !chan_on_o[0])
		else $error("faulted channel left on");

endmodule // octal_serial_output_driver_ctrl
`default_nettype wire

// File: verif/spi_master_model.sv
// link master model: drives frames and collects the returned bits
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
	import osd_pkg::*;
(
	// link pins toward the device
	output var link_in_t link_o,
	input wire logic so_i
);
	// idle: deselected, shift clock parked low
	initial begin
		link_o = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
	end
	// one frame of nbits; rx gathers so, first bit lands highest
	task automatic frame(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		// step off the system clock edge so the pins never race the samplers
		#1;
		link_o.cs_n = 1'b0;
		#250;
		for (int i = nbits - 1; i >= 0; i--) begin
			link_o.si = tx[i];
			link_o.sclk = 1'b1;
			#62.5;
			// so has long settled before the falling edge
			rx = {rx[14:0], so_i};
			link_o.sclk = 1'b0;
			#62.5;
		end
		// lag time before deselect, clock still low
		#190;
		link_o.cs_n = 1'b1;
		// a released data line shows the inverse of its last value
		link_o.si = ~link_o.si;
	endtask
endmodule // spi_master_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the octal driver control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import osd_pkg::*;
	// short hold-off keeps the run brief
	localparam int unsigned HOLD = 20;
	localparam int LIMIT = 40000;
	logic clk_i, rst_i, ce_i, clear_n_i, cmd_ready_i;
	logic [CH_W-1:0] sense_i, chan_on_o;
	logic [LOG_W-1:0] cmd_data_o;
	logic so_o, so_oe_n_o, cmd_valid_o, cmd_room_o;
	link_in_t link;
	wire so_line;
	int failures, check_count, cycles;
	logic [15:0] rx;

	// so pin floats while the device leaves it undriven
	assign so_line = so_oe_n_o ? 1'bz : so_o;

	spi_master_model spi (.link_o(link), .so_i(so_line));
	octal_serial_output_driver_ctrl #(.HOLD_CYCLES(HOLD)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .clear_n_i(clear_n_i),
		.link_i(link), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
		.sense_i(sense_i), .chan_on_o(chan_on_o),
		.cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o),
		.cmd_ready_i(cmd_ready_i), .cmd_room_o(cmd_room_o)
	);

	// free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			failures++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// pin levels during the frame, then the pin levels to hold once it ends
	task automatic xfer(input int nb, input logic [15:0] tx, input logic [7:0] s0,
		input logic [7:0] s1);
		@(posedge clk_i) sense_i <= s0;
		ticks(4);
		spi.frame(nb, tx, rx);
		@(posedge clk_i) sense_i <= s1;
	endtask

	task automatic t_reset();
		check({8'h00, chan_on_o}, 16'h0000);
		check({15'h0000, so_oe_n_o}, 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_basic();
		xfer(8, 16'h005A, 8'hA5, 8'h5A);
		check(rx, 16'h00A5);
		ticks(10);
		check({8'h00, chan_on_o}, 16'h00A5);
		check({15'h0000, so_oe_n_o}, 16'h0001);
		$display("test basic done");
	endtask
	task automatic t_chain();
		xfer(16, 16'hC33C, 8'h96, 8'h3C);
		check(rx, 16'h96C3);
		ticks(10);
		check({8'h00, chan_on_o}, 16'h00C3);
		$display("test chain done");
	endtask
	task automatic t_empty();
		// no clock pulses: latch takes the inverse of the captured pin levels
		xfer(0, 16'h0000, 8'h0F, 8'hF0);
		ticks(10);
		check({8'h00, chan_on_o}, 16'h00F0);
		$display("test empty done");
	endtask
	task automatic t_fault();
		// channels 2 and 3 on, channel 2 pin then stays high
		xfer(8, 16'h00F3, 8'hF3, 8'hF7);
		ticks(8);
		check({8'h00, chan_on_o}, 16'h000C);
		ticks(40);
		check({8'h00, chan_on_o}, 16'h0008);
		$display("test fault done");
	endtask
	task automatic t_log();
		int n;
		int k;
		n = 0;
		k = 0;
		@(posedge clk_i) cmd_ready_i <= 1'b0;
		while (cmd_room_o === 1'b1 && n < 20) begin
			xfer(8, n[15:0], n[7:0], n[7:0]);
			ticks(10);
			n++;
		end
		check(n[15:0], 16'(LOG_DEPTH + 1));
		// one more commit while full: latched, but missing from the log
		xfer(8, 16'h0055, 8'h55, 8'h55);
		ticks(10);
		check({8'h00, chan_on_o}, 16'h00AA);
		@(posedge clk_i) cmd_ready_i <= 1'b1;
		repeat (60) begin
			@(posedge clk_i);
			if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) begin
				check({8'h00, cmd_data_o}, k[15:0]);
				k++;
			end
		end
		check(k[15:0], n[15:0]);
		$display("test log done");
	endtask
	task automatic t_clear();
		@(posedge clk_i) clear_n_i <= 1'b0;
		ticks(2);
		check({8'h00, chan_on_o}, 16'h0000);
		@(posedge clk_i) clear_n_i <= 1'b1;
		ticks(5);
		// a frozen block must not commit a frame that passes while enable is low
		@(posedge clk_i) ce_i <= 1'b0;
		xfer(8, 16'h0000, 8'h00, 8'h00);
		ticks(10);
		check({8'h00, chan_on_o}, 16'h0000);
		@(posedge clk_i) ce_i <= 1'b1;
		ticks(10);
		check({8'h00, chan_on_o}, 16'h0000);
		$display("test clear done");
	endtask

	// main sequence
	initial begin
		rst_i = 1'b1;
		clear_n_i = 1'b1;
		ce_i = 1'b1;
		cmd_ready_i = 1'b1;
		sense_i = 8'h00;
		failures = 0;
		check_count = 0;
		cycles = 0;
		rx = 16'h0000;
		ticks(10);
		rst_i <= 1'b0;
		ticks(5);
		t_reset();
		t_basic();
		t_chain();
		t_empty();
		t_fault();
		t_log();
		t_clear();
		test_done();
	end
endmodule // tb
`default_nettype wire
